// ### pkg/sgm_pkg.sv
// Overview of operation
// - modulator runs only while the module enable bit is one.
// - disabled: both carrier selects forced to ground, polarity bits still applied after, modulator taken from software bit.
// - stored source selections survive disable and apply again on re-enable.
// - output disabled with module enabled: mixing runs, pin held low.
// - four-bit field picks the modulator from sixteen sources.
// - four-bit field picks carrier high from clocks, peripherals, pins, ground.
// - separate four-bit field picks carrier low from the same set.
// - leaving a synced carrier: other carrier at once, synced until its falling edge.
// - returning to synced carrier: other cut at once, synced waits falling edge.
// - each carrier path has its own synchronisation enable bit.
// - each carrier path has its own polarity inversion bit.
// - software modulator bit value drives the modulator when selected.
// - output invert bit inverts the signal on the output pin.
// - block keeps working in sleep while its sources run.
// - any reset disables the block and restores all control registers.
package sgm_pkg;
    localparam logic [3:0] ADR_CONTROL = 4'h0;
    localparam logic [3:0] ADR_MOD_SRC = 4'h4;
    localparam logic [3:0] ADR_CAR_HIGH = 4'h8;
    localparam logic [3:0] ADR_CAR_LOW = 4'hC;
    // control register fields
    localparam int CTL_ENABLE = 7;
    localparam int CTL_OUT_EN = 6;
    localparam int CTL_OUT_INV = 4;
    localparam int CTL_SOFT_BIT = 0;
    localparam logic [7:0] CTL_WMASK = 8'hD1;
    // carrier register fields
    localparam int CAR_INV = 7;
    localparam int CAR_SYNC = 6;
    localparam logic [7:0] CAR_WMASK = 8'hCF;
    localparam logic [7:0] MOD_WMASK = 8'h0F;
    localparam logic [7:0] RST_VALUE = 8'h00;
    // modulator source codes
    localparam logic [3:0] MOD_SEL_SOFT = 4'h0;
    localparam logic [3:0] MOD_SEL_EXT_PIN = 4'h9;
    // carrier source codes
    localparam logic [3:0] CAR_SEL_GROUND = 4'h0;
    localparam logic [3:0] CAR_SEL_SYSCLK = 4'h6;
    localparam logic [3:0] CAR_SEL_FAST_OSC = 4'h7;
    localparam logic [3:0] CAR_SEL_REF_CLK = 4'hC;
    localparam logic [3:0] CAR_SEL_PIN_A = 4'hD;
    localparam logic [3:0] CAR_SEL_PIN_B = 4'hE;
endpackage

// ### design/sgm_carrier_path.sv
`timescale 1ns/1ps
// one carrier: source select, inversion, falling-edge sync gate
module sgm_carrier_path
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [15:0] sources,
    input wire logic [3:0] select,
    input wire logic invert,
    input wire logic syncEn,
    input wire logic wanted,
    output logic gateOn,
    output logic carrier
);
    import sgm_pkg::*;
    typedef struct packed {
        logic prev;
        logic gate;
    } sgm_car_state_t;
    sgm_car_state_t st_q, st_d;
    logic fallEdge;

    // selected and polarity-adjusted carrier
    assign carrier = sources[select] ^ invert;
    assign fallEdge = st_q.prev & ~carrier;

    // gate changes only on falling edge when synced
    always_comb
    begin
        st_d = st_q;
        st_d.prev = carrier;
        if (!syncEn)
            st_d.gate = wanted;
        else if (fallEdge)
            st_d.gate = wanted;
    end

    // gate stays open after release until edge; sync only acts when enabled
    assign gateOn = syncEn ? st_q.gate : wanted;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            st_q <= '0;
        else
            st_q <= st_d;
    end
endmodule

// ### design/sgm_wb_regs.sv
`timescale 1ns/1ps
// wishbone classic slave for the four control registers
module sgm_wb_regs
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [7:0] statusBits,
    output logic [7:0] controlReg,
    output logic [7:0] modSrcReg,
    output logic [7:0] carHighReg,
    output logic [7:0] carLowReg
);
    import sgm_pkg::*;
    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] mod;
        logic [7:0] ch;
        logic [7:0] cl;
        logic ack;
        logic [31:0] rdat;
    } sgm_reg_state_t;
    sgm_reg_state_t st_q, st_d;
    logic req;

    // masked byte-lane write
    function automatic logic [7:0] wr8(input logic [7:0] old, input logic [7:0] nw, input logic [7:0] m);
        wr8 = (old & ~m) | (nw & m);
    endfunction

    assign req = wb_cyc_i & wb_stb_i & ~st_q.ack;

    // one-wait answer; ack drops the cycle after it is given
    // write commits at the ack edge, so a master that quits early changes nothing
    always_comb
    begin
        st_d = st_q;
        st_d.ack = req;
        st_d.rdat = 32'h0000_0000;
        if (wb_cyc_i && wb_stb_i && st_q.ack && wb_we_i && wb_sel_i[0])
        begin
            case (wb_adr_i)
                ADR_CONTROL: st_d.ctl = wr8(st_q.ctl, wb_dat_i[7:0], CTL_WMASK);
                ADR_MOD_SRC: st_d.mod = wr8(st_q.mod, wb_dat_i[7:0], MOD_WMASK);
                ADR_CAR_HIGH: st_d.ch = wr8(st_q.ch, wb_dat_i[7:0], CAR_WMASK);
                ADR_CAR_LOW: st_d.cl = wr8(st_q.cl, wb_dat_i[7:0], CAR_WMASK);
                default: st_d.ctl = st_q.ctl;
            endcase
        end
        if (req && !wb_we_i)
        begin
            case (wb_adr_i)
                ADR_CONTROL: st_d.rdat = {24'h000000, st_q.ctl | statusBits};
                ADR_MOD_SRC: st_d.rdat = {24'h000000, st_q.mod};
                ADR_CAR_HIGH: st_d.rdat = {24'h000000, st_q.ch};
                ADR_CAR_LOW: st_d.rdat = {24'h000000, st_q.cl};
                default: st_d.rdat = 32'h0000_0000; // unmapped reads zero
            endcase
        end
    end

    // reset restores defaults
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_q <= '0;
            st_q.ctl <= RST_VALUE;
            st_q.mod <= RST_VALUE;
            st_q.ch <= RST_VALUE;
            st_q.cl <= RST_VALUE;
        end
        else
            st_q <= st_d;
    end

    assign wb_ack_o = st_q.ack;
    assign wb_dat_o = st_q.rdat;
    assign controlReg = st_q.ctl;
    assign modSrcReg = st_q.mod;
    assign carHighReg = st_q.ch;
    assign carLowReg = st_q.cl;
endmodule

// ### design/sgm_signal_modulator.sv
`timescale 1ns/1ps
// top of the signal modulator
module sgm_signal_modulator
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [15:0] modSources,
    input wire logic [15:0] carSources,
    input wire logic externalModulatorPin,
    input wire logic externalCarrierPinA,
    input wire logic externalCarrierPinB,
    input wire logic internalFastOscillator,
    input wire logic referenceClockOutput,
    input wire logic sysClkCarrier,
    output logic modOut
);
    import sgm_pkg::*;
    typedef struct packed {
        logic outBit;
    } sgm_top_state_t;
    sgm_top_state_t st_q, st_d;
    logic [7:0] controlReg;
    logic [7:0] modSrcReg;
    logic [7:0] carHighReg;
    logic [7:0] carLowReg;
    logic [15:0] modVec;
    logic [15:0] carVec;
    logic enabled;
    logic modulator;
    logic [3:0] chSel;
    logic [3:0] clSel;
    logic chGate;
    logic clGate;
    logic chSig;
    logic clSig;
    logic mixed;

    sgm_wb_regs u_regs
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .statusBits({2'b00, st_q.outBit, 5'b00000}),
        .controlReg(controlReg),
        .modSrcReg(modSrcReg),
        .carHighReg(carHighReg),
        .carLowReg(carLowReg)
    );

    assign enabled = controlReg[CTL_ENABLE];

    // fixed source tables; named pins patched into their codes
    always_comb
    begin
        modVec = modSources;
        modVec[MOD_SEL_SOFT] = controlReg[CTL_SOFT_BIT];
        modVec[MOD_SEL_EXT_PIN] = externalModulatorPin;
        carVec = carSources;
        carVec[CAR_SEL_GROUND] = 1'b0;
        carVec[CAR_SEL_SYSCLK] = sysClkCarrier;
        carVec[CAR_SEL_FAST_OSC] = internalFastOscillator;
        carVec[CAR_SEL_REF_CLK] = referenceClockOutput;
        carVec[CAR_SEL_PIN_A] = externalCarrierPinA;
        carVec[CAR_SEL_PIN_B] = externalCarrierPinB;
    end

    // disable overrides selections without touching stored fields
    assign modulator = enabled ? modVec[modSrcReg[3:0]] : controlReg[CTL_SOFT_BIT];
    assign chSel = enabled ? carHighReg[3:0] : CAR_SEL_GROUND;
    assign clSel = enabled ? carLowReg[3:0] : CAR_SEL_GROUND;

    sgm_carrier_path u_high
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .sources(carVec),
        .select(chSel),
        .invert(carHighReg[CAR_INV]),
        .syncEn(carHighReg[CAR_SYNC]),
        .wanted(modulator),
        .gateOn(chGate),
        .carrier(chSig)
    );

    sgm_carrier_path u_low
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .sources(carVec),
        .select(clSel),
        .invert(carLowReg[CAR_INV]),
        .syncEn(carLowReg[CAR_SYNC]),
        .wanted(~modulator),
        .gateOn(clGate),
        .carrier(clSig)
    );

    // gated carriers ORed; overlap only during sync hand-over
    assign mixed = (chGate & chSig) | (clGate & clSig);

    // registered pin; low when output gated, no sleep dependence
    always_comb
    begin
        st_d = st_q;
        if (enabled && controlReg[CTL_OUT_EN])
            st_d.outBit = mixed ^ controlReg[CTL_OUT_INV];
        else
            st_d.outBit = 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign modOut = st_q.outBit;
endmodule

// ### test/sgm_src_model.sv
`timescale 1ns/1ps
// far-side sources: free-running carriers and pins at differing rates
module sgm_src_model
(
    input wire logic clk,
    output logic [15:0] carSrc,
    output logic [5:0] pins
);
    logic [15:0] cntQ = 16'h0000;
    // odd step so each bit toggles at its own rate, never stops
    always_ff @(posedge clk)
        cntQ <= cntQ + 16'h0007;
    assign carSrc = cntQ ^ {cntQ[2:0], cntQ[15:3]};
    assign pins = cntQ[7:2];
endmodule

// ### test/sgm_signal_modulator_monitor.sv
`timescale 1ns/1ps
// bus handshake and pin gating checks
module sgm_signal_modulator_monitor
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic modOut
);
    import sgm_pkg::*;
    logic [7:0] ctlQ;
    logic take;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // shadow written at the ack edge, same edge the slave writes
    always_ff @(posedge clk)
        if (sys_rst)
            ctlQ <= RST_VALUE;
        else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_CONTROL)
            ctlQ <= wb_dat_i[7:0] & CTL_WMASK;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_take; take; endsequence
    sequence s_answer; wb_ack_o ##1 !wb_ack_o; endsequence
    a_ack_next: assert property (s_take |=> s_answer) else $error("ack late or long");
    a_ack_cause: assert property (wb_ack_o |-> $past(take)) else $error("ack without request");
    a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000) else $error("upper bits set");
    a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[1:0] != 2'h0 |-> wb_dat_o == 32'h00000000)
        else $error("unmapped read not zero");
    a_ctl_back: assert property (wb_ack_o && !wb_we_i && wb_adr_i == ADR_CONTROL |-> (wb_dat_o[7:0] & CTL_WMASK) == ctlQ)
        else $error("control readback wrong");
    a_pin_off: assert property (!(ctlQ[CTL_ENABLE] && ctlQ[CTL_OUT_EN]) |=> !modOut)
        else $error("pin driven while off");
    a_dis_low: assert property ($fell(ctlQ[CTL_ENABLE]) |=> !modOut [*2])
        else $error("pin high after disable");
    a_rst_quiet: assert property (disable iff (1'b0) sys_rst |=> !modOut && !wb_ack_o)
        else $error("outputs active in reset");
endmodule

bind sgm_signal_modulator sgm_signal_modulator_monitor u_sgm_signal_modulator_monitor (.clk, .sys_rst, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .modOut);

// ### test/sgm_signal_modulator_tb_top.sv
`timescale 1ns/1ps
module sgm_signal_modulator_tb_top;
    import sgm_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h00000000;
    logic [31:0] rdo;
    logic [31:0] rdat;
    logic [15:0] modSrc = 16'h0000;
    logic [15:0] carSrc;
    logic [5:0] pins;
    logic ack;
    logic modOut;
    logic expQ;
    logic skipQ = 1'b1;
    logic hGateQ = 1'b0;
    logic lGateQ = 1'b0;
    logic hPrevQ = 1'b0;
    logic lPrevQ = 1'b0;
    logic pinAtTake = 1'b0;
    logic [7:0] sh [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] wm [4] = '{CTL_WMASK, MOD_WMASK, CAR_WMASK, CAR_WMASK};
    logic [31:0] seed = 32'hAAD8984D;
    int nFail = 0;
    int testsRun = 0;
    int cycles = 0;
    sgm_signal_modulator u_sgm_signal_modulator (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdo), .wb_ack_o(ack),
        .modSources(modSrc), .carSources(carSrc), .externalModulatorPin(pins[0]), .externalCarrierPinA(pins[1]),
        .externalCarrierPinB(pins[2]), .internalFastOscillator(pins[3]), .referenceClockOutput(pins[4]),
        .sysClkCarrier(pins[5]), .modOut(modOut));
    sgm_src_model u_sgm_src_model (.clk(clk), .carSrc(carSrc), .pins(pins));
    initial forever #10 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    // carrier pick, forced to ground while disabled, invert after pick
    function automatic logic car(input logic [7:0] r, input logic en);
        logic c;
        case (en ? r[3:0] : CAR_SEL_GROUND)
            CAR_SEL_GROUND: c = 1'b0;
            CAR_SEL_SYSCLK: c = pins[5];
            CAR_SEL_FAST_OSC: c = pins[3];
            CAR_SEL_REF_CLK: c = pins[4];
            CAR_SEL_PIN_A: c = pins[1];
            CAR_SEL_PIN_B: c = pins[2];
            default: c = carSrc[r[3:0]];
        endcase
        return c ^ r[CAR_INV];
    endfunction
    // rule model; a synced gate follows its request only after that carrier falls
    task automatic modelStep();
        logic e;
        logic m;
        logic ch;
        logic cl;
        logic gh;
        logic gl;
        e = sh[0][CTL_ENABLE];
        m = sh[0][CTL_SOFT_BIT];
        if (e && sh[1][3:0] != MOD_SEL_SOFT)
            m = sh[1][3:0] == MOD_SEL_EXT_PIN ? pins[0] : modSrc[sh[1][3:0]];
        ch = car(sh[2], e);
        cl = car(sh[3], e);
        gh = sh[2][CAR_SYNC] ? hGateQ : m;
        gl = sh[3][CAR_SYNC] ? lGateQ : !m;
        expQ = e && sh[0][CTL_OUT_EN] && (((gh && ch) || (gl && cl)) ^ sh[0][CTL_OUT_INV]);
        if (!sh[2][CAR_SYNC] || (hPrevQ && !ch))
            hGateQ = m;
        if (!sh[3][CAR_SYNC] || (lPrevQ && !cl))
            lGateQ = !m;
        hPrevQ = ch;
        lPrevQ = cl;
        if (sys_rst)
        begin
            hGateQ = 1'b0;
            lGateQ = 1'b0;
            hPrevQ = 1'b0;
            lPrevQ = 1'b0;
        end
    endtask
    task automatic chkPin(input logic e, input logic g);
        testsRun++;
        if (g !== e)
        begin
            nFail++;
            $display("BAD %0t pin %b want %b", $time, g, e);
        end
    endtask
    task automatic reportAndStop();
        $display("mismatches %0d of %0d", nFail, testsRun);
        if (nFail == 0 && testsRun > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic wbx(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h1;
        dat <= {24'h000000, d};
        // pin as it stood when the slave took the request
        do
        begin
            @(posedge clk);
            if (ack !== 1'b1)
                pinAtTake = modOut;
        end
        while (ack !== 1'b1);
        rdat = rdo;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (w && a[1:0] == 2'h0)
            sh[a[3:2]] = d & wm[a[3:2]];
    endtask
    // read back; control bit 5 mirrors the pin as it stood at the take edge
    task automatic rd(input logic [3:0] a);
        logic [31:0] e;
        wbx(1'b0, a, 8'h00);
        e = a[1:0] != 2'h0 ? 32'h0 : {24'h0, sh[a[3:2]]};
        if (a == ADR_CONTROL)
            e[5] = pinAtTake;
        testsRun++;
        if (rdat !== e)
        begin
            nFail++;
            $display("BAD %0t read %h want %h", $time, rdat, e);
        end
    endtask
    task automatic rst(input int n);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (n) @(posedge clk);
        sys_rst <= 1'b0;
        foreach (sh[i]) sh[i] = RST_VALUE;
    endtask
    // pin compared with last settled expectation, skipped during any bus cycle and reset
    always @(negedge clk)
    begin
        if (!skipQ)
            chkPin(expQ, modOut);
        modelStep();
        skipQ = cyc || sys_rst;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 12000)
        begin
            nFail++;
            $display("BAD %0t run too long", $time);
            reportAndStop();
        end
    end
    initial
    begin
        rst(12);
        foreach (wm[i]) rd(4'(4 * i));
        rd(4'h6);
        for (int i = 0; i < 48; i++)
        begin
            seed = xs(seed);
            wbx(1'b1, ADR_MOD_SRC, {4'h0, i[3:0]});
            wbx(1'b1, ADR_CAR_HIGH, {seed[7], seed[9], 2'h0, ~i[3:0]});
            wbx(1'b1, ADR_CAR_LOW, {seed[8], seed[10], 2'h0, i[3:0] + 4'h5});
            wbx(1'b1, ADR_CONTROL, {seed[31:30] | {2{i[1]}}, seed[29:24]});
            wbx(1'b1, ADR_CONTROL, 8'h00);
            wbx(1'b1, ADR_CONTROL, {2'h3, seed[29:24]});
            rd(seed[2] ? ADR_CAR_HIGH : 4'h6);
            repeat (30)
            begin
                @(posedge clk);
                seed = xs(seed);
                modSrc <= seed[15:0];
            end
        end
        rst(3);
        rd(ADR_CONTROL);
        // synced high carrier that really falls, plain inverted low carrier
        wbx(1'b1, ADR_CAR_HIGH, 8'h41);
        wbx(1'b1, ADR_CAR_LOW, 8'h83);
        for (int k = 0; k < 16; k++)
        begin
            wbx(1'b1, ADR_CONTROL, {7'h60, k[0]});
            repeat (6) @(posedge clk);
        end
        reportAndStop();
    end
endmodule
